/* File: hdl/adof_formatter.sv */
//
// Contract
// - one modulator sample taken every clock while power_down_n is high
// - normal mode decimates by six
// - double-rate select decimates by three
// - result is 16-bit two's complement
// - all sixteen bits presented together
// - above full scale gives 7FFF, flag high
// - below full scale gives 8000, flag high
// - flag holds while results stay out
// - flag changes only at strobe fall
// - strobe falls to mark each word
// - bus driven only with select and read low
// - sync low clears word, flag, sums and registers; phase loads 5, strobe high

// -----------------------------------------------------------------
// two-stage synchroniser
// -----------------------------------------------------------------
module adof_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= RESET_VAL;
      pinSync    <= RESET_VAL;
    end else begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end
endmodule

// -----------------------------------------------------------------
// formatter top
// -----------------------------------------------------------------
module adof_formatter (
  input  wire logic                            core_clk,
  input  wire logic                            arst_n,
  input  wire logic signed [adof_pkg::MOD_W-1:0] modSample,
  input  wire logic                            double_rate_select,
  input  wire logic                            power_down_n,
  input  wire logic                            chipSelect_n,
  input  wire logic                            readEnable_n,
  output logic        [adof_pkg::WORD_W-1:0]   dataOut,
  output logic                                 dataOutEn,
  output logic                                 out_of_range_flag,
  output logic                                 word_valid_strobe_n,
  output logic                                 irq,
  input  wire adof_pkg::adof_avs_req_t         avsReq,
  output logic        [31:0]                   avsReadData,
  output logic                                 avsWaitrequest
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic rateSync;
  logic pwrSync_n;
  logic csSync_n;
  logic rdSync_n;

  adof_sync #(.RESET_VAL(1'b0)) uRateSync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (double_rate_select),
    .pinSync  (rateSync)
  );
  adof_sync #(.RESET_VAL(1'b1)) uPwrSync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (power_down_n),
    .pinSync  (pwrSync_n)
  );
  adof_sync #(.RESET_VAL(1'b1)) uCsSync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (chipSelect_n),
    .pinSync  (csSync_n)
  );
  adof_sync #(.RESET_VAL(1'b1)) uRdSync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (readEnable_n),
    .pinSync  (rdSync_n)
  );

  // ---------------------------------------------------------------
  // control register and rate selection
  // ---------------------------------------------------------------
  logic [adof_pkg::CTRL_W-1:0] ctrl_reg;
  logic                        doubleRate;
  logic                        rateHeld_reg;
  logic [2:0]                  ratio;
  logic                        running;

  assign doubleRate = rateSync | ctrl_reg[adof_pkg::CTRL_RATE];
  assign ratio      = rateHeld_reg ? adof_pkg::RATIO_DOUBLE : adof_pkg::RATIO_NORMAL;
  assign running    = pwrSync_n;

  // ---------------------------------------------------------------
  // decimation phase and accumulator
  // ---------------------------------------------------------------
  logic [2:0]                        phase_reg;
  logic                              lastPhase;
  logic signed [adof_pkg::SUM_W-1:0] acc_reg;
  logic signed [adof_pkg::SUM_W-1:0] accSum;
  logic signed [adof_pkg::SUM_W-1:0] sum_reg;
  logic                              sumValid_reg;

  // ratio only changes at a wrap, so the phase never passes it
  assign lastPhase = phase_reg >= (ratio - 3'h1);
  assign accSum    = acc_reg + adof_pkg::SUM_W'(modSample);

  // rate change waits for a word boundary, keeping strobe and sum whole
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rateHeld_reg <= 1'b0;
    end else if (running && lastPhase) begin
      rateHeld_reg <= doubleRate;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= adof_pkg::PHASE_RST;
    end else if (running) begin
      phase_reg <= lastPhase ? 3'h0 : phase_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else if (running) begin
      acc_reg <= lastPhase ? '0 : accSum;
    end
  end

  // sum of three is doubled to share the divide-by-six scaling
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_reg      <= '0;
      sumValid_reg <= 1'b0;
    end else begin
      sumValid_reg <= running & lastPhase;
      if (running && lastPhase) begin
        sum_reg <= rateHeld_reg ? (accSum <<< 1) : accSum;
      end
    end
  end

  // ---------------------------------------------------------------
  // scaling and saturation
  // ---------------------------------------------------------------
  logic signed [adof_pkg::PROD_W-1:0]  product;
  logic signed [adof_pkg::WIDE_W-1:0]  wideResult;
  logic                                overPos;
  logic                                underNeg;
  logic        [adof_pkg::WORD_W-1:0]  clipWord;

  assign product    = sum_reg * $signed({1'b0, adof_pkg::RECIP_SIX});
  assign wideResult = product[adof_pkg::RECIP_SHIFT +: adof_pkg::WIDE_W];
  assign overPos    = wideResult > $signed(adof_pkg::WIDE_W'(adof_pkg::POS_FULL));
  assign underNeg   = wideResult < -$signed(adof_pkg::WIDE_W'(adof_pkg::NEG_FULL));

  always_comb begin
    if (overPos) begin
      clipWord = adof_pkg::POS_FULL;
    end else if (underNeg) begin
      clipWord = adof_pkg::NEG_FULL;
    end else begin
      clipWord = wideResult[adof_pkg::WORD_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // output word, flag and strobe
  // ---------------------------------------------------------------
  logic [adof_pkg::WORD_W-1:0] word_reg;
  logic [2:0]                  strobeCnt_reg;
  logic                        rangeNext;

  assign rangeNext = overPos | underNeg;

  // word and flag load on the same edge that drops the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg          <= adof_pkg::WORD_RST;
      out_of_range_flag <= 1'b0;
    end else if (sumValid_reg) begin
      word_reg          <= clipWord;
      out_of_range_flag <= rangeNext;
    end
  end

  // strobe low for half the word period, rounded down
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_valid_strobe_n <= 1'b1;
      strobeCnt_reg       <= 3'h0;
    end else if (sumValid_reg) begin
      word_valid_strobe_n <= 1'b0;
      strobeCnt_reg       <= (ratio >> 1) - 3'h1;
    end else if (strobeCnt_reg != 3'h0) begin
      strobeCnt_reg <= strobeCnt_reg - 3'h1;
    end else begin
      word_valid_strobe_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // parallel output bus
  // ---------------------------------------------------------------
  logic busSelected;

  assign busSelected = !csSync_n && !rdSync_n && !ctrl_reg[adof_pkg::CTRL_BUSOFF];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut   <= adof_pkg::WORD_RST;
      dataOutEn <= 1'b0;
    end else begin
      dataOutEn <= busSelected;
      dataOut   <= busSelected ? (sumValid_reg ? clipWord : word_reg) : adof_pkg::WORD_RST;
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  adof_pkg::adof_event_t       events;
  logic [adof_pkg::EV_W-1:0]   irqStat_reg;
  logic [adof_pkg::EV_W-1:0]   irqEn_reg;
  logic [adof_pkg::EV_W-1:0]   clearBits;
  logic                        busAccept;
  logic                        wrClear;

  assign events.newWord     = sumValid_reg;
  assign events.flagEntered = sumValid_reg & rangeNext & !out_of_range_flag;
  assign events.flagLeft    = sumValid_reg & !rangeNext & out_of_range_flag;
  assign wrClear           = busAccept && avsReq.write && avsReq.address == adof_pkg::IRQ_CLR_OFS
                             && avsReq.byteenable[0];
  assign clearBits         = wrClear ? avsReq.writedata[adof_pkg::EV_W-1:0] : adof_pkg::EV_RST;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_reg <= adof_pkg::EV_RST;
    end else begin
      irqStat_reg <= (irqStat_reg & ~clearBits) | events;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irqStat_reg & ~clearBits) | events) & irqEn_reg);
    end
  end

  // ---------------------------------------------------------------
  // avalon slave
  // ---------------------------------------------------------------
  adof_pkg::adof_bus_state_t busState_reg;
  logic                      busReq;
  logic [31:0]               readMux;

  assign busReq    = avsReq.read | avsReq.write;
  assign busAccept = busReq && busState_reg == adof_pkg::BUS_ACK;

  // one wait cycle, then the request completes on the next edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busState_reg   <= adof_pkg::BUS_IDLE;
      avsWaitrequest <= 1'b1;
    end else begin
      unique case (busState_reg)
        adof_pkg::BUS_IDLE: begin
          if (busReq) begin
            busState_reg   <= adof_pkg::BUS_ACK;
            avsWaitrequest <= 1'b0;
          end
        end
        adof_pkg::BUS_ACK: begin
          busState_reg   <= adof_pkg::BUS_IDLE;
          avsWaitrequest <= 1'b1;
        end
        default: begin
          busState_reg   <= adof_pkg::BUS_IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= adof_pkg::CTRL_RST;
    end else if (busAccept && avsReq.write && avsReq.address == adof_pkg::CTRL_OFS && avsReq.byteenable[0]) begin
      ctrl_reg <= avsReq.writedata[adof_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_reg <= adof_pkg::EV_RST;
    end else if (busAccept && avsReq.write && avsReq.address == adof_pkg::IRQ_EN_OFS && avsReq.byteenable[0]) begin
      irqEn_reg <= avsReq.writedata[adof_pkg::EV_W-1:0];
    end
  end

  always_comb begin
    readMux = adof_pkg::RDATA_RST;
    unique case (avsReq.address)
      adof_pkg::CTRL_OFS: begin
        readMux[adof_pkg::CTRL_W-1:0] = ctrl_reg;
      end
      adof_pkg::STATUS_OFS: begin
        readMux[adof_pkg::STAT_FLAG]  = out_of_range_flag;
        readMux[adof_pkg::STAT_RATE]  = doubleRate;
        readMux[adof_pkg::STAT_PDOWN] = !pwrSync_n;
      end
      adof_pkg::IRQ_STAT_OFS: begin
        readMux[adof_pkg::EV_W-1:0] = irqStat_reg;
      end
      adof_pkg::IRQ_EN_OFS: begin
        readMux[adof_pkg::EV_W-1:0] = irqEn_reg;
      end
      adof_pkg::WORD_OFS: begin
        readMux[adof_pkg::WORD_W-1:0] = word_reg;
      end
      default: begin
        readMux = adof_pkg::RDATA_RST;
      end
    endcase
  end

  // read data loaded as waitrequest drops, held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avsReadData <= adof_pkg::RDATA_RST;
    end else if (avsReq.read && busState_reg == adof_pkg::BUS_IDLE) begin
      avsReadData <= readMux;
    end
  end

endmodule

/* File: hdl/adof_pkg.sv */
package adof_pkg;

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam int          MOD_W        = 17;
  localparam int          SUM_W        = 21;
  localparam int          WIDE_W       = 21;
  localparam int          RECIP_W      = 16;
  localparam int          PROD_W       = SUM_W + RECIP_W + 1;
  localparam int          RECIP_SHIFT  = 17;
  localparam logic [15:0] RECIP_SIX    = 16'h5555;
  localparam logic [2:0]  RATIO_NORMAL = 3'h6;
  localparam logic [2:0]  RATIO_DOUBLE = 3'h3;
  localparam logic [2:0]  PHASE_RST    = 3'h5;
  localparam logic [15:0] POS_FULL     = 16'h7FFF;
  localparam logic [15:0] NEG_FULL     = 16'h8000;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  CTRL_OFS     = 5'h00;
  localparam logic [4:0]  STATUS_OFS   = 5'h04;
  localparam logic [4:0]  IRQ_STAT_OFS = 5'h08;
  localparam logic [4:0]  IRQ_EN_OFS   = 5'h0C;
  localparam logic [4:0]  IRQ_CLR_OFS  = 5'h10;
  localparam logic [4:0]  WORD_OFS     = 5'h14;
  localparam int          CTRL_RATE    = 0;
  localparam int          CTRL_BUSOFF  = 1;
  localparam int          CTRL_W       = 2;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam int          STAT_FLAG    = 0;
  localparam int          STAT_RATE    = 1;
  localparam int          STAT_PDOWN   = 2;
  localparam int          EV_W         = 3;
  localparam logic [2:0]  EV_RST       = 3'h0;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } adof_avs_req_t;

  typedef struct packed {
    logic flagLeft;
    logic flagEntered;
    logic newWord;
  } adof_event_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } adof_bus_state_t;

endpackage

/* File: tb/adof_formatter_checker.sv */
module adof_formatter_checker (
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  input wire logic                        chipSelect_n,
  input wire logic                        readEnable_n,
  input wire logic [adof_pkg::WORD_W-1:0] dataOut,
  input wire logic                        dataOutEn,
  input wire logic                        out_of_range_flag,
  input wire logic                        word_valid_strobe_n,
  input wire adof_pkg::adof_avs_req_t     avsReq,
  input wire logic                        avsWaitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] gapCnt;
  logic       strobeLast;
  logic       seenFall;
  // ---------------------------------------------
  // cycles since the last strobe fall
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gapCnt     <= 4'h0;
      strobeLast <= 1'b1;
      seenFall   <= 1'b0;
    end else begin
      strobeLast <= word_valid_strobe_n;
      if (strobeLast && !word_valid_strobe_n) begin
        gapCnt   <= 4'h1;
        seenFall <= 1'b1;
      end else if (gapCnt != 4'hF) begin
        gapCnt <= gapCnt + 4'h1;
      end
    end
  end
  a_word_gap: assert property ($fell(word_valid_strobe_n) && seenFall
    |-> gapCnt >= 4'h3 && gapCnt <= 4'h6) else $error("strobe spacing wrong");
  a_strobe_width: assert property ($fell(word_valid_strobe_n)
    |-> (!word_valid_strobe_n [*3] ##1 word_valid_strobe_n) or (##1 word_valid_strobe_n))
    else $error("strobe low width wrong");
  a_after_sync: assert property ($rose(arst_n) |-> word_valid_strobe_n && !out_of_range_flag
    && !dataOutEn && dataOut == adof_pkg::WORD_RST ##2 $fell(word_valid_strobe_n))
    else $error("state after sync wrong");
  a_flag_step: assert property ($changed(out_of_range_flag) |-> $fell(word_valid_strobe_n))
    else $error("flag moved off strobe fall");
  a_clip_code: assert property (out_of_range_flag && $past(out_of_range_flag)
    && dataOutEn && $past(dataOutEn) |-> dataOut == adof_pkg::POS_FULL || dataOut == adof_pkg::NEG_FULL)
    else $error("flagged word not clipped");
  a_bus_gate: assert property (dataOutEn |-> !$past(chipSelect_n, 3) && !$past(readEnable_n, 3))
    else $error("bus driven without select");
  a_bus_quiet: assert property (!dataOutEn |-> dataOut == adof_pkg::WORD_RST)
    else $error("idle bus not zero");
  a_wait_answer: assert property ((avsReq.read || avsReq.write) && avsWaitrequest |=> !avsWaitrequest)
    else $error("no answer after one wait");
  a_wait_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
endmodule

bind adof_formatter adof_formatter_checker chk (.core_clk(core_clk), .arst_n(arst_n),
  .chipSelect_n(chipSelect_n), .readEnable_n(readEnable_n), .dataOut(dataOut), .dataOutEn(dataOutEn),
  .out_of_range_flag(out_of_range_flag), .word_valid_strobe_n(word_valid_strobe_n),
  .avsReq(avsReq), .avsWaitrequest(avsWaitrequest));

/* File: tb/adof_formatter_test.sv */
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_count++; $display("[ERR] %s exp=%h got=%h", nm, ex, gt); end end
module adof_formatter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                core_clk = 1'b0;
  logic                                arst_n = 1'b0;
  logic signed [adof_pkg::MOD_W-1:0]   modSample = '0;
  logic                                double_rate_select = 1'b0;
  logic                                power_down_n = 1'b1;
  logic                                enable = 1'b1;
  logic                                slow = 1'b0;
  adof_pkg::adof_avs_req_t             avsReq = '0;
  logic                                chipSelect_n, readEnable_n, dataOutEn, out_of_range_flag;
  logic                                word_valid_strobe_n, irq, avsWaitrequest, lastFlag, lastEn;
  logic [adof_pkg::WORD_W-1:0]         dataOut, lastWord;
  logic [31:0]                         avsReadData;
  logic [16:0]                         exp;
  int                                  wordCount, err_count, compares;
  int samples[9] = '{0, 1000, -1000, 32768, 32769, -32768, -32769, 65535, -65536};

  always #2 core_clk = ~core_clk;

  adof_formatter uut (.core_clk(core_clk), .arst_n(arst_n), .modSample(modSample),
    .double_rate_select(double_rate_select), .power_down_n(power_down_n), .chipSelect_n(chipSelect_n),
    .readEnable_n(readEnable_n), .dataOut(dataOut), .dataOutEn(dataOutEn), .out_of_range_flag(out_of_range_flag),
    .word_valid_strobe_n(word_valid_strobe_n), .irq(irq), .avsReq(avsReq), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest));
  adof_reader dsp (.core_clk(core_clk), .arst_n(arst_n), .enable(enable), .slow(slow), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .out_of_range_flag(out_of_range_flag), .word_valid_strobe_n(word_valid_strobe_n),
    .chipSelect_n(chipSelect_n), .readEnable_n(readEnable_n), .lastWord(lastWord), .lastFlag(lastFlag),
    .lastEn(lastEn), .wordCount(wordCount));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [16:0] expect_word(input int s);
    longint p;
    p = (longint'(s) * 6 * longint'(adof_pkg::RECIP_SIX)) >>> adof_pkg::RECIP_SHIFT;
    if (p > longint'(adof_pkg::POS_FULL)) return {1'b1, adof_pkg::POS_FULL};
    if (p < -longint'(adof_pkg::NEG_FULL)) return {1'b1, adof_pkg::NEG_FULL};
    return {1'b0, p[15:0]};
  endfunction
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    avsReq <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: wd};
    do begin
      @(posedge core_clk);
    end while (avsWaitrequest !== 1'b0);
    rd = avsReadData;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic reg_chk(input string nm, input logic [4:0] a, input logic [31:0] ex);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    `CHK(nm, ex, d)
  endtask
  task automatic words(input int k);
    int c0;
    c0 = wordCount;
    while (wordCount < c0 + k) begin
      @(posedge core_clk);
    end
  endtask
  task automatic period(input int ex);
    time t0;
    @(negedge word_valid_strobe_n);
    t0 = $time;
    @(negedge word_valid_strobe_n);
    `CHK("period", ex, int'(($time - t0) / 4))
  endtask
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_count++;
    complete_run();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    reg_chk("ctrl", adof_pkg::CTRL_OFS, 32'h0000_0000);
    reg_chk("irq en", adof_pkg::IRQ_EN_OFS, 32'h0000_0000);
    reg_chk("unmapped", 5'h1C, 32'h0000_0000);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      double_rate_select <= m[0];
      words(2);
      period(m ? 3 : 6);
      for (int i = 0; i < 9; i++) begin
        modSample <= 17'(samples[i]);
        slow <= i[0];
        words(4);
        exp = expect_word(samples[i]);
        `CHK("word", exp[15:0], lastWord)
        `CHK("flag", exp[16], lastFlag)
        `CHK("bus on", 1'b1, lastEn)
        reg_chk("last word", adof_pkg::WORD_OFS, {16'h0000, exp[15:0]});
      end
    end
    $display("test codes done");
    modSample <= '0;
    words(3);
    wr(adof_pkg::IRQ_CLR_OFS, 32'h0000_0007);
    wr(adof_pkg::IRQ_EN_OFS, 32'h0000_0002);
    `CHK("irq idle", 1'b0, irq)
    modSample <= 17'(40000);
    words(3);
    repeat (12) begin
      @(posedge core_clk);
      `CHK("flag hold", 1'b1, out_of_range_flag)
    end
    `CHK("irq set", 1'b1, irq)
    reg_chk("irq stat", adof_pkg::IRQ_STAT_OFS, 32'h0000_0003);
    wr(adof_pkg::IRQ_EN_OFS, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(adof_pkg::IRQ_EN_OFS, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(adof_pkg::IRQ_CLR_OFS, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    wr(adof_pkg::CTRL_OFS, 32'h0000_0002);
    repeat (4) @(posedge core_clk);
    `CHK("bus off", 1'b0, dataOutEn)
    wr(adof_pkg::CTRL_OFS, 32'h0000_0001);
    enable <= 1'b0;
    words(2);
    period(3);
    reg_chk("status", adof_pkg::STATUS_OFS, 32'h0000_0003);
    `CHK("cs off", 1'b0, dataOutEn)
    `CHK("cs off data", 16'h0000, dataOut)
    enable <= 1'b1;
    $display("test bus done");
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("sync strobe", 1'b1, word_valid_strobe_n)
    `CHK("sync word", 16'h0000, dataOut)
    `CHK("sync flag", 1'b0, out_of_range_flag)
    @(posedge core_clk);
    arst_n <= 1'b1;
    words(2);
    reg_chk("ctrl after sync", adof_pkg::CTRL_OFS, 32'h0000_0000);
    $display("test sync done");
    complete_run();
  end
endmodule

/* File: tb/adof_reader.sv */
module adof_reader (
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  input wire logic                        enable,
  input wire logic                        slow,
  input wire logic [adof_pkg::WORD_W-1:0] dataOut,
  input wire logic                        dataOutEn,
  input wire logic                        out_of_range_flag,
  input wire logic                        word_valid_strobe_n,
  output logic                            chipSelect_n,
  output logic                            readEnable_n,
  output logic [adof_pkg::WORD_W-1:0]     lastWord,
  output logic                            lastFlag,
  output logic                            lastEn,
  output int                              wordCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       strobeLast;
  logic [1:0] pend;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chipSelect_n <= 1'b1;
      readEnable_n <= 1'b1;
    end else begin
      chipSelect_n <= !enable;
      readEnable_n <= !enable;
    end
  end
  // word taken two or three cycles after the strobe falls
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobeLast <= 1'b1;
      pend       <= 2'h0;
      lastWord   <= 16'h0000;
      lastFlag   <= 1'b0;
      lastEn     <= 1'b0;
      wordCount  <= 0;
    end else begin
      strobeLast <= word_valid_strobe_n;
      pend       <= {pend[0], strobeLast & !word_valid_strobe_n};
      if (slow ? pend[1] : pend[0]) begin
        lastWord  <= dataOut;
        lastFlag  <= out_of_range_flag;
        lastEn    <= dataOutEn;
        wordCount <= wordCount + 1;
      end
    end
  end
endmodule
